// ---- pkg/tbf_pkg.sv ----
// shared constants and types for the tape block format generator and drive end
// How it works
// - eight tracks, numbered zero to seven
// - even tracks forward, odd tracks reverse
// - 158 cylinders per track, zero to 157
// - logical blocks run zero to 1263
// - eight sectors per block, ids one to eight
// - each data field holds 1024 bytes
// - header: 80 gap, 12 zero, 50 gap
// - header carries three C2 then FC
// - fill data fields with 6D
// - block content within 9562 bytes
// - host formats block like a floppy track
// - whole block written as one track pass
// - block zero parameters stored twice; the formatter builds every block, block zero too, once only
// - update mode rewrites one sector alone
// - start/stop positions without losing capacity
// - streaming moves continuously, no block stops
// - host keeps streaming data without gaps
// - sector id: zeros, marks, FE, address, crc
// - sector size flag is 03
// - data field: marks, FB, data, crc, gap
package tbf_pkg;

    // ------------------------------------------------------------------
    // tape geometry
    // ------------------------------------------------------------------
    localparam logic [3:0]  NUM_TRACKS     = 4'h8;
    localparam logic [2:0]  MAX_TRACK      = 3'h7;
    localparam logic [10:0] CYLS_PER_TRACK = 11'h09e;
    localparam logic [7:0]  MAX_CYL        = 8'h9d;
    localparam logic [10:0] MAX_LBN        = 11'h4ef;
    localparam logic [3:0]  NUM_SECTORS    = 4'h8;
    localparam logic [3:0]  FIRST_SECTOR   = 4'h1;
    localparam logic [13:0] BLOCK_CAPACITY = 14'h255a;

    // ------------------------------------------------------------------
    // field lengths in bytes
    // ------------------------------------------------------------------
    localparam logic [10:0] HDR_GAP_LEN    = 11'h050;
    localparam logic [10:0] SYNC_ZERO_LEN  = 11'h00c;
    localparam logic [10:0] MARK_LEN       = 11'h003;
    localparam logic [10:0] HDR_TAIL_LEN   = 11'h032;
    localparam logic [10:0] CRC_LEN        = 11'h002;
    localparam logic [10:0] ID_GAP_LEN     = 11'h016;
    localparam logic [10:0] SECTOR_BYTES   = 11'h400;
    localparam logic [10:0] DATA_GAP_LEN   = 11'h036;
    localparam logic [10:0] SINGLE_LEN     = 11'h001;

    // ------------------------------------------------------------------
    // byte values
    // ------------------------------------------------------------------
    localparam logic [7:0]  GAP_BYTE       = 8'h4e;
    localparam logic [7:0]  ZERO_BYTE      = 8'h00;
    localparam logic [7:0]  INDEX_MARK     = 8'hc2;
    localparam logic [7:0]  INDEX_TYPE     = 8'hfc;
    localparam logic [7:0]  SYNC_MARK      = 8'ha1;
    localparam logic [7:0]  ID_TYPE        = 8'hfe;
    localparam logic [7:0]  DATA_TYPE      = 8'hfb;
    localparam logic [7:0]  SIZE_FLAG      = 8'h03;
    localparam logic [7:0]  FILL_BYTE      = 8'h6d;
    localparam logic [15:0] CRC_INIT       = 16'hffff;
    localparam logic [15:0] CRC_POLY       = 16'h1021;

    // ------------------------------------------------------------------
    // drive operating modes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_STREAM = 2'b00,
        MODE_START_STOP = 2'b01,
        MODE_UPDATE = 2'b10
    } tbf_mode_t;

endpackage

// ---- pkg/tbf_link_if.sv ----
// byte link between the block formatter and the tape drive end
`timescale 1ns/100ps
interface tbf_link_if;
    logic       byte_valid;
    logic [7:0] byte_data;
    logic       byte_mark;
    logic       byte_ready;
    logic       blk_first;
    logic       blk_last;
    logic [2:0] blk_track;
    logic [7:0] blk_cyl;

    modport fmt (
        output byte_valid,
        output byte_data,
        output byte_mark,
        input  byte_ready,
        output blk_first,
        output blk_last,
        output blk_track,
        output blk_cyl
    );

    modport drv (
        input  byte_valid,
        input  byte_data,
        input  byte_mark,
        output byte_ready,
        input  blk_first,
        input  blk_last,
        input  blk_track,
        input  blk_cyl
    );
endinterface

// ---- rtl/tbf_drive.sv ----
// tape drive end: takes the block byte stream and steers the head
`timescale 1ns/100ps
module tbf_drive (
    input  wire logic          i_sys_clk,
    input  wire logic          i_rst_n,
    tbf_link_if.drv            link,
    input  wire logic [1:0]    i_mode,
    input  wire logic [3:0]    i_update_sector,
    input  wire logic          i_motion_ok,
    output logic [2:0]         o_track,
    output logic [7:0]         o_cyl,
    output logic               o_dir_reverse,
    output logic               o_wr_strobe,
    output logic [7:0]         o_wr_byte,
    output logic               o_wr_mark,
    output logic               o_underrun,
    output logic               o_overflow,
    output logic               o_pos_err,
    output logic               o_index
);
    logic        take;
    logic        in_block;
    logic [13:0] blk_cnt;
    logic [1:0]  mark_run;
    logic        id_phase;
    logic [1:0]  id_idx;
    logic        data_phase;
    logic [10:0] data_cnt;
    logic [3:0]  cur_sector;
    logic        sel_write;

    // head only accepts bytes while the tape moves under it
    assign link.byte_ready = i_motion_ok;
    assign take            = link.byte_valid && i_motion_ok;

    // ------------------------------------------------------------------
    // block position and direction
    // ------------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            o_track       <= 3'h0;
            o_cyl         <= 8'h00;
            o_dir_reverse <= 1'b0;
            o_pos_err     <= 1'b0;
        end else if (take && link.blk_first) begin
            o_track       <= link.blk_track;
            o_cyl         <= link.blk_cyl;
            o_dir_reverse <= link.blk_track[0];
            o_pos_err     <= (link.blk_cyl > tbf_pkg::MAX_CYL);
        end
    end

    // ------------------------------------------------------------------
    // block framing, capacity and streaming checks
    // ------------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            in_block <= 1'b0;
            blk_cnt  <= 14'h0000;
            o_index  <= 1'b0;
        end else begin
            o_index <= take && link.blk_last;
            if (take) begin
                blk_cnt  <= link.blk_first ? 14'h0001 : blk_cnt + 14'h0001;
                in_block <= !link.blk_last;
            end
        end
    end

    // sticky; cleared only by reset
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            o_overflow <= 1'b0;
        end else if (take && !link.blk_first && blk_cnt >= tbf_pkg::BLOCK_CAPACITY) begin
            o_overflow <= 1'b1;
        end
    end

    // a missing byte mid-block while streaming records a gap
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            o_underrun <= 1'b0;
        end else if (i_mode == tbf_pkg::MODE_STREAM && in_block && i_motion_ok
                     && !link.byte_valid) begin
            o_underrun <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // mark parser: finds sector id and data fields
    // ------------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            mark_run   <= 2'h0;
            id_phase   <= 1'b0;
            id_idx     <= 2'h0;
            data_phase <= 1'b0;
            data_cnt   <= 11'h000;
            cur_sector <= 4'h0;
        end else if (take) begin
            if (link.byte_mark && link.byte_data == tbf_pkg::SYNC_MARK) begin
                mark_run <= (mark_run == 2'h3) ? 2'h3 : mark_run + 2'h1;
            end else begin
                mark_run <= 2'h0;
            end
            if (mark_run == 2'h3 && link.byte_data == tbf_pkg::ID_TYPE) begin
                id_phase <= 1'b1;
                id_idx   <= 2'h0;
            end else if (id_phase) begin
                id_idx <= id_idx + 2'h1;
                if (id_idx == 2'h2) begin
                    cur_sector <= link.byte_data[3:0];
                end
                if (id_idx == 2'h3) begin
                    id_phase <= 1'b0;
                end
            end
            if (mark_run == 2'h3 && link.byte_data == tbf_pkg::DATA_TYPE) begin
                data_phase <= 1'b1;
                data_cnt   <= 11'h000;
            end else if (data_phase) begin
                data_cnt <= data_cnt + 11'h001;
                if (data_cnt == tbf_pkg::SECTOR_BYTES + tbf_pkg::CRC_LEN - 11'h001) begin
                    data_phase <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // head write gating
    // ------------------------------------------------------------------
    // in update mode only the chosen sector's data and crc reach the head
    assign sel_write = (i_mode != tbf_pkg::MODE_UPDATE)
                       || (data_phase && cur_sector == i_update_sector);

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            o_wr_strobe <= 1'b0;
            o_wr_byte   <= 8'h00;
            o_wr_mark   <= 1'b0;
        end else begin
            o_wr_strobe <= take && sel_write;
            if (take) begin
                o_wr_byte <= link.byte_data;
                o_wr_mark <= link.byte_mark;
            end
        end
    end
endmodule

// ---- rtl/tbf_formatter.sv ----
// host formatter end: builds one formatted tape block as a byte stream
`timescale 1ns/100ps
module tbf_formatter (
    input  wire logic          i_sys_clk,
    input  wire logic          i_rst_n,
    tbf_link_if.fmt            link,
    input  wire logic          i_start,
    input  wire logic [2:0]    i_track,
    input  wire logic [7:0]    i_cyl,
    input  wire logic          i_use_fill,
    input  wire logic [7:0]    i_user_byte,
    output logic               o_user_take,
    output logic               o_busy,
    output logic               o_done,
    output logic               o_addr_err,
    output logic [10:0]        o_lbn
);
    // ------------------------------------------------------------------
    // block layout segments
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        SEG_HGAP   = 5'h00,
        SEG_HZERO  = 5'h01,
        SEG_IMARK  = 5'h02,
        SEG_ITYPE  = 5'h03,
        SEG_HTAIL  = 5'h04,
        SEG_SZERO  = 5'h05,
        SEG_IDMARK = 5'h06,
        SEG_IDTYPE = 5'h07,
        SEG_CYL    = 5'h08,
        SEG_HEAD   = 5'h09,
        SEG_SECT   = 5'h0a,
        SEG_SIZE   = 5'h0b,
        SEG_IDCRC  = 5'h0c,
        SEG_IDGAP  = 5'h0d,
        SEG_DZERO  = 5'h0e,
        SEG_DMARK  = 5'h0f,
        SEG_DTYPE  = 5'h10,
        SEG_DATA   = 5'h11,
        SEG_DCRC   = 5'h12,
        SEG_DGAP   = 5'h13
    } tbf_seg_t;

    tbf_seg_t    seg;
    logic [10:0] cnt;
    logic [3:0]  sector;
    logic [15:0] crc;
    logic [2:0]  trk;
    logic [7:0]  cyl;
    logic        advance;
    logic        seg_end;
    logic        blk_end;
    logic        first_pend;
    logic [7:0]  cur_byte;
    logic        cur_mark;
    logic        crc_cover;

    function automatic logic [10:0] seg_len(input tbf_seg_t s);
        case (s)
            SEG_HGAP:  seg_len = tbf_pkg::HDR_GAP_LEN;
            SEG_HZERO: seg_len = tbf_pkg::SYNC_ZERO_LEN;
            SEG_IMARK: seg_len = tbf_pkg::MARK_LEN;
            SEG_HTAIL: seg_len = tbf_pkg::HDR_TAIL_LEN;
            SEG_SZERO: seg_len = tbf_pkg::SYNC_ZERO_LEN;
            SEG_IDMARK: seg_len = tbf_pkg::MARK_LEN;
            SEG_IDCRC: seg_len = tbf_pkg::CRC_LEN;
            SEG_IDGAP: seg_len = tbf_pkg::ID_GAP_LEN;
            SEG_DZERO: seg_len = tbf_pkg::SYNC_ZERO_LEN;
            SEG_DMARK: seg_len = tbf_pkg::MARK_LEN;
            SEG_DATA:  seg_len = tbf_pkg::SECTOR_BYTES;
            SEG_DCRC:  seg_len = tbf_pkg::CRC_LEN;
            SEG_DGAP:  seg_len = tbf_pkg::DATA_GAP_LEN;
            default:   seg_len = tbf_pkg::SINGLE_LEN;
        endcase
    endfunction

    // ccitt crc, msb first, marks included as on a floppy track
    function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            if (r[15] ^ d[i]) begin
                r = {r[14:0], 1'b0} ^ tbf_pkg::CRC_POLY;
            end else begin
                r = {r[14:0], 1'b0};
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------------
    // byte selection
    // ------------------------------------------------------------------
    always_comb begin
        cur_mark  = 1'b0;
        crc_cover = 1'b0;
        case (seg)
            SEG_HGAP, SEG_HTAIL, SEG_IDGAP, SEG_DGAP: cur_byte = tbf_pkg::GAP_BYTE;
            SEG_HZERO, SEG_SZERO, SEG_DZERO: cur_byte = tbf_pkg::ZERO_BYTE;
            SEG_IMARK: begin
                cur_byte = tbf_pkg::INDEX_MARK;
                cur_mark = 1'b1;
            end
            SEG_ITYPE: cur_byte = tbf_pkg::INDEX_TYPE;
            SEG_IDMARK, SEG_DMARK: begin
                cur_byte  = tbf_pkg::SYNC_MARK;
                cur_mark  = 1'b1;
                crc_cover = 1'b1;
            end
            SEG_IDTYPE: begin
                cur_byte  = tbf_pkg::ID_TYPE;
                crc_cover = 1'b1;
            end
            SEG_CYL: begin
                cur_byte  = cyl;
                crc_cover = 1'b1;
            end
            SEG_HEAD: begin
                cur_byte  = tbf_pkg::ZERO_BYTE;
                crc_cover = 1'b1;
            end
            SEG_SECT: begin
                cur_byte  = {4'h0, sector};
                crc_cover = 1'b1;
            end
            SEG_SIZE: begin
                cur_byte  = tbf_pkg::SIZE_FLAG;
                crc_cover = 1'b1;
            end
            SEG_DTYPE: begin
                cur_byte  = tbf_pkg::DATA_TYPE;
                crc_cover = 1'b1;
            end
            SEG_DATA: begin
                cur_byte  = i_use_fill ? tbf_pkg::FILL_BYTE : i_user_byte;
                crc_cover = 1'b1;
            end
            SEG_IDCRC, SEG_DCRC: cur_byte = (cnt == 11'h000) ? crc[15:8] : crc[7:0];
            default: cur_byte = tbf_pkg::GAP_BYTE;
        endcase
    end

    // one output register; back-pressure from the drive stalls generation
    assign advance     = o_busy && (!link.byte_valid || link.byte_ready);
    assign seg_end     = (cnt == seg_len(seg) - 11'h001);
    assign blk_end     = seg_end && seg == SEG_DGAP && sector == tbf_pkg::NUM_SECTORS;
    assign o_user_take = advance && seg == SEG_DATA && !i_use_fill;

    // ------------------------------------------------------------------
    // start and block address
    // ------------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            trk        <= 3'h0;
            cyl        <= 8'h00;
            o_lbn      <= 11'h000;
            o_addr_err <= 1'b0;
        end else begin
            o_addr_err <= 1'b0;
            if (i_start && !o_busy) begin
                if (i_track > tbf_pkg::MAX_TRACK || i_cyl > tbf_pkg::MAX_CYL) begin
                    o_addr_err <= 1'b1;
                end else begin
                    trk   <= i_track;
                    cyl   <= i_cyl;
                    // serpentine tracks still number cylinders from their own start
                    o_lbn <= 11'(i_track) * tbf_pkg::CYLS_PER_TRACK
                             + 11'(i_cyl);
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // segment sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            o_busy     <= 1'b0;
            o_done     <= 1'b0;
            seg        <= SEG_HGAP;
            cnt        <= 11'h000;
            sector     <= tbf_pkg::FIRST_SECTOR;
            first_pend <= 1'b0;
        end else begin
            o_done <= 1'b0;
            if (!o_busy) begin
                if (i_start && i_track <= tbf_pkg::MAX_TRACK && i_cyl <= tbf_pkg::MAX_CYL) begin
                    o_busy     <= 1'b1;
                    seg        <= SEG_HGAP;
                    cnt        <= 11'h000;
                    sector     <= tbf_pkg::FIRST_SECTOR;
                    first_pend <= 1'b1;
                end
            end else if (advance) begin
                first_pend <= 1'b0;
                if (!seg_end) begin
                    cnt <= cnt + 11'h001;
                end else begin
                    cnt <= 11'h000;
                    if (blk_end) begin
                        o_busy <= 1'b0;
                        o_done <= 1'b1;
                    end else if (seg == SEG_DGAP) begin
                        seg    <= SEG_SZERO;
                        sector <= sector + 4'h1;
                    end else begin
                        seg <= tbf_seg_t'(seg + 5'h01);
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // crc over each id and data field
    // ------------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            crc <= tbf_pkg::CRC_INIT;
        end else if (advance && crc_cover) begin
            if ((seg == SEG_IDMARK || seg == SEG_DMARK) && cnt == 11'h000) begin
                crc <= crc_upd(tbf_pkg::CRC_INIT, cur_byte);
            end else begin
                crc <= crc_upd(crc, cur_byte);
            end
        end
    end

    // ------------------------------------------------------------------
    // link output register
    // ------------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            link.byte_valid <= 1'b0;
            link.byte_data  <= 8'h00;
            link.byte_mark  <= 1'b0;
            link.blk_first  <= 1'b0;
            link.blk_last   <= 1'b0;
        end else if (advance) begin
            link.byte_valid <= 1'b1;
            link.byte_data  <= cur_byte;
            link.byte_mark  <= cur_mark;
            link.blk_first  <= first_pend;
            link.blk_last   <= blk_end;
        end else if (link.byte_ready) begin
            link.byte_valid <= 1'b0;
            link.blk_first  <= 1'b0;
            link.blk_last   <= 1'b0;
        end
    end

    // address stays put for the whole block
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            link.blk_track <= 3'h0;
            link.blk_cyl   <= 8'h00;
        end else begin
            link.blk_track <= trk;
            link.blk_cyl   <= cyl;
        end
    end
endmodule

// ---- bench/tbf_link_properties.sv ----
// checker for the formatter to drive byte link
`timescale 1ns/100ps
module tbf_link_properties (
    input wire logic       i_sys_clk,
    input wire logic       i_rst_n,
    input wire logic       byte_valid,
    input wire logic [7:0] byte_data,
    input wire logic       byte_mark,
    input wire logic       byte_ready,
    input wire logic       blk_first,
    input wire logic       blk_last,
    input wire logic [2:0] blk_track,
    input wire logic [7:0] blk_cyl
);
    logic [13:0] pos;
    logic [13:0] p;
    logic [10:0] q;
    logic        tk;
    assign tk = byte_valid && byte_ready;
    assign p  = blk_first ? 14'h0 : pos;
    // offset inside a sector, only meaningful past the header
    assign q  = 11'((p - 14'h92) % 14'h474);
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) pos <= 14'h0;
        else if (tk) pos <= p + 14'h1;
    end
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    hold_valid_a: assert property (byte_valid && !byte_ready |=> byte_valid
        && $stable(byte_data) && $stable(blk_first)) else $error("byte changed while stalled");
    cyl_range_a: assert property (byte_valid |-> blk_cyl <= 8'h9d)
        else $error("cylinder out of range");
    addr_hold_a: assert property (tk && !blk_last ##1 byte_valid && !blk_first
        |-> $stable(blk_cyl) && $stable(blk_track)) else $error("address moved in block");
    header_gap_a: assert property (tk && p < 14'h50 |-> byte_data == 8'h4e && !byte_mark)
        else $error("bad leading gap");
    zero_run_a: assert property (tk && p >= 14'h50 && p < 14'h5c |-> byte_data == 8'h00)
        else $error("bad zero run");
    index_mark_a: assert property (tk && p >= 14'h5c && p < 14'h5f
        |-> byte_mark && byte_data == 8'hc2) else $error("bad index mark");
    index_type_a: assert property (tk && p == 14'h5f |-> byte_data == 8'hfc)
        else $error("bad index type byte");
    size_flag_a: assert property (tk && p >= 14'h92 && q == 11'h13 |-> byte_data == 8'h03)
        else $error("bad size flag");
    data_mark_a: assert property (tk && p >= 14'h92 && q == 11'h3b |-> byte_data == 8'hfb)
        else $error("bad data mark");
    block_len_a: assert property (tk && blk_last |-> p == 14'h2431)
        else $error("block length wrong");
    cover property (tk && blk_last);
    cover property (byte_valid && !byte_ready);
    cover property (tk && blk_first);
endmodule

// ---- bench/tb_tape_block_format_gen.sv ----
// self-checking bench: formatter and drive joined over the byte link
`timescale 1ns/100ps
module tb_tape_block_format_gen;
    typedef struct {
        logic [2:0] t;
        logic [7:0] c;
        logic       f;
        logic [1:0] m;
        logic [3:0] s;
        logic       st;
    } tbf_row_t;
    logic        i_sys_clk = 1'b0;
    logic        i_rst_n = 1'b0;
    logic        i_start = 1'b0;
    logic        i_use_fill = 1'b0;
    logic        i_motion_ok = 1'b1;
    logic [2:0]  i_track = 3'h0;
    logic [7:0]  i_cyl = 8'h00;
    logic [7:0]  i_user_byte = 8'h5a;
    logic [1:0]  i_mode = 2'h0;
    logic [3:0]  i_update_sector = 4'h1;
    logic        o_user_take, o_busy, o_done, o_addr_err, o_dir_reverse, o_wr_strobe;
    logic        o_wr_mark, o_underrun, o_overflow, o_pos_err, o_index;
    logic [10:0] o_lbn;
    logic [2:0]  o_track;
    logic [7:0]  o_cyl, o_wr_byte, ecyl;
    logic [9:0]  e;
    logic [8:0]  lastb = 9'h000;
    logic        efill, stall = 1'b0;
    int          err_total = 0, checks = 0, idx = 0, p = 0, nwr = 0, nidx = 0, cyc = 0, nut = 0;
    tbf_row_t    rows [4] = '{'{3'h0, 8'h00, 1'b0, 2'h0, 4'h1, 1'b0},
                              '{3'h7, 8'h9d, 1'b0, 2'h1, 4'h1, 1'b1},
                              '{3'h1, 8'h00, 1'b1, 2'h2, 4'h8, 1'b0},
                              '{3'h4, 8'h64, 1'b1, 2'h2, 4'h3, 1'b1}};
    tbf_link_if link_bus ();
    tbf_formatter u_tbf_formatter (.i_sys_clk, .i_rst_n, .link(link_bus), .i_start, .i_track,
        .i_cyl, .i_use_fill, .i_user_byte, .o_user_take, .o_busy, .o_done, .o_addr_err, .o_lbn);
    tbf_drive u_tbf_drive (.i_sys_clk, .i_rst_n, .link(link_bus), .i_mode, .i_update_sector,
        .i_motion_ok, .o_track, .o_cyl, .o_dir_reverse, .o_wr_strobe, .o_wr_byte, .o_wr_mark,
        .o_underrun, .o_overflow, .o_pos_err, .o_index);
    tbf_link_properties u_tbf_link_properties (.i_sys_clk, .i_rst_n,
        .byte_valid(link_bus.byte_valid), .byte_data(link_bus.byte_data),
        .byte_mark(link_bus.byte_mark), .byte_ready(link_bus.byte_ready),
        .blk_first(link_bus.blk_first), .blk_last(link_bus.blk_last),
        .blk_track(link_bus.blk_track), .blk_cyl(link_bus.blk_cyl));
    always #10 i_sys_clk = ~i_sys_clk;
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    // --------------------------------------------------------------
    // expected {check, mark, byte} at block position p; crc not modelled
    // --------------------------------------------------------------
    function automatic logic [9:0] exp_b(input int p);
        int q;
        if (p < 80 || (p >= 96 && p < 146)) return 10'h24e;
        if (p < 92) return 10'h200;
        if (p < 95) return 10'h3c2;
        if (p < 96) return 10'h2fc;
        q = (p - 146) % 1140;
        if (q < 12 || (q >= 44 && q < 56) || q == 17) return 10'h200;
        if (q < 15 || (q >= 56 && q < 59)) return 10'h3a1;
        if (q == 15) return 10'h2fe;
        if (q == 16) return {2'b10, ecyl};
        if (q == 18) return 10'h201 + 10'((p - 146) / 1140);
        if (q == 19) return 10'h203;
        if (q == 59) return 10'h2fb;
        if (q >= 60 && q < 1084) return {2'b10, efill ? 8'h6d : 8'h5a};
        if (q < 22 || (q >= 1084 && q < 1086)) return 10'h000;
        return 10'h24e;
    endfunction
    always @(posedge i_sys_clk) begin
        cyc <= cyc + 1;
        // one dead cycle in seven while stalling
        i_motion_ok <= !(stall && cyc % 7 == 3);
        // head shows the byte taken one edge earlier
        if (o_wr_strobe) chk({o_wr_mark, o_wr_byte}, lastb);
        if (link_bus.byte_valid && link_bus.byte_ready) begin
            p = link_bus.blk_first ? 0 : idx;
            e = exp_b(p);
            if (e[9])
                chk({link_bus.byte_mark, link_bus.byte_data}, e[8:0]);
            chk(link_bus.blk_last, p == 9265);
            lastb = {link_bus.byte_mark, link_bus.byte_data};
            idx = p + 1;
        end
        if (o_wr_strobe) nwr++;
        if (o_index) nidx++;
        if (o_user_take) nut++;
    end
    task automatic run_row(input tbf_row_t r);
        int n;
        @(posedge i_sys_clk);
        {i_track, i_cyl, i_use_fill, i_mode} <= {r.t, r.c, r.f, r.m};
        {i_update_sector, stall, i_start} <= {r.s, r.st, 1'b1};
        {ecyl, efill, nwr, nidx, nut, idx, n} = {r.c, r.f, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
        @(posedge i_sys_clk) i_start <= 1'b0;
        repeat (50) @(posedge i_sys_clk);
        // start while busy must be ignored
        {i_start, i_cyl} <= {1'b1, 8'h05};
        @(posedge i_sys_clk) i_start <= 1'b0;
        while (o_done !== 1'b1 && n < 30000) begin
            @(posedge i_sys_clk);
            n++;
        end
        repeat (5) @(posedge i_sys_clk);
        chk(o_lbn, r.t * 158 + r.c);
        chk(n < 30000, 1'b1);
        chk(idx, 9266);
        chk(nut, r.f ? 0 : 8192);
        chk(nwr, r.m == 2'h2 ? 1026 : 9266);
        chk(nidx, 1);
        chk(o_track, r.t);
        chk(o_cyl, r.c);
        chk(o_dir_reverse, r.t[0]);
        chk({o_underrun, o_overflow, o_pos_err}, 3'h0);
        $display("row test done track %0d cyl %0d", r.t, r.c);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge i_sys_clk);
        err_total++;
        final_report();
    end
    initial begin
        repeat (20) @(posedge i_sys_clk);
        chk({link_bus.byte_valid, o_busy, o_done, o_index}, 4'h0);
        $display("reset test done");
        i_rst_n <= 1'b1;
        @(posedge i_sys_clk);
        foreach (rows[k]) run_row(rows[k]);
        // cylinder 158 is one past the last valid one
        @(posedge i_sys_clk);
        {i_cyl, i_start} <= {8'h9e, 1'b1};
        @(posedge i_sys_clk) i_start <= 1'b0;
        #1 chk(o_addr_err, 1'b1);
        repeat (3) @(posedge i_sys_clk);
        chk({o_busy, link_bus.byte_valid}, 2'h0);
        chk(o_lbn, 11'h2dc);
        $display("address refusal test done");
        final_report();
    end
endmodule
